/* File: hdl/ccp_center_pulse.sv */
// module: zone tracking, centre crossing pulse and indicator logic
`timescale 1ns/1ps
module ccp_center_pulse
    import ccp_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES,
    parameter int HOLD_LEN  = RESET_HOLD_CYCLES
)(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // analogue front end, asynchronous to mclk
    input  wire logic [1:0]           zone_in,
    input  wire logic [RAW_BITS-1:0]  raw_seq,
    input  wire logic                 raw_valid,
    // controller commands from the data interface logic
    input  wire logic                 pulse_clear,
    input  wire logic                 antenna_off,
    // code telegram out
    output logic      [CODE_BITS-1:0] code_out,
    output logic                      code_strobe,
    // position output and lamps
    output logic                      position_pulse,
    output logic                      carrier_indicator,
    output logic                      code_read_indicator
);
    // every front end pin crosses two flops; the raw word must stand still from
    // before its strobe rises, so both of its stages are settled when it is taken
    typedef struct packed {
        logic [1:0]           zone_s1;
        logic [1:0]           zone_s2;
        logic [RAW_BITS-1:0]  raw_s1;
        logic [RAW_BITS-1:0]  raw_s2;
        logic                 rv_s1;
        logic                 rv_s2;
        logic                 rv_d;
        ccp_zone_t            zone_prev;
        ccp_state_t           fsm;
        logic [CNT_BITS-1:0]  cnt;
        logic [CODE_BITS-1:0] last_code;
        logic                 last_valid;
        logic [CODE_BITS-1:0] cur_code;
        logic                 cur_valid;
        logic [CODE_BITS-1:0] out_code;
        logic                 out_stb;
        logic                 pulse;
        logic                 carrier;
        logic                 dataled;
    } ccp_core_t;

    ccp_core_t st;
    ccp_core_t next_st;

    logic [CODE_BITS-1:0] dec_code;
    logic                 dec_valid;
    logic                 raw_take;
    ccp_zone_t            zone;

    assign raw_take = st.rv_s2 & ~st.rv_d;

    ccp_decode u_decode (
        .mclk      (mclk),
        .resetn    (resetn),
        .raw_seq   (st.raw_s2),
        .raw_valid (raw_take),
        .dec_code  (dec_code),
        .dec_valid (dec_valid)
    );

    function automatic logic [CNT_BITS-1:0] len_of(input int n);
        return (n < 1) ? CNT_BITS'(1) : CNT_BITS'(n);
    endfunction : len_of

    // outer or inner zone, where codes are read and the data lamp is lit
    function automatic logic in_field(input ccp_zone_t z);
        return (z == CCP_ZONE_OUTER) || (z == CCP_ZONE_INNER);
    endfunction : in_field

    always_comb begin
        next_st         = st;
        next_st.zone_s1 = zone_in;
        next_st.zone_s2 = st.zone_s1;
        next_st.raw_s1  = raw_seq;
        next_st.raw_s2  = st.raw_s1;
        next_st.rv_s1   = raw_valid;
        next_st.rv_s2   = st.rv_s1;
        next_st.rv_d    = st.rv_s2;
        next_st.out_stb = 1'b0;

        // deactivated antenna sees no zone at all
        zone = antenna_off ? CCP_ZONE_NONE : ccp_zone_t'(st.zone_s2);
        next_st.zone_prev = zone;

        next_st.dataled = in_field(zone);
        next_st.carrier = (zone == CCP_ZONE_INNER);

        // report codes read in either zone
        // no code read in the gap or while off leaves here
        if (dec_valid && !antenna_off && in_field(zone)) begin
            // code kept at full 16 bits
            next_st.cur_code  = dec_code;
            next_st.cur_valid = 1'b1;
            next_st.out_code  = dec_code;
            next_st.out_stb   = 1'b1;
        end
        if (zone == CCP_ZONE_NONE) begin
            next_st.cur_valid = 1'b0;
        end

        // a different code read releases the suppression
        if (next_st.cur_valid && st.last_valid && next_st.cur_code != st.last_code) begin
            next_st.last_valid = 1'b0;
        end

        // clear forgets the stored code; a pulse stored in the same
        // cycle still wins, so its own repeat stays suppressed
        if (pulse_clear) begin
            next_st.last_valid = 1'b0;
            next_st.last_code  = CODE_RESET;
        end

        case (st.fsm)
            CCP_ST_POWERUP: begin
                // pulse held high through the reset period
                next_st.pulse = 1'b1;
                next_st.cnt   = st.cnt + CNT_BITS'(1);
                if (st.cnt >= len_of(HOLD_LEN) - CNT_BITS'(1)) begin
                    next_st.pulse = 1'b0;
                    next_st.cnt   = '0;
                    next_st.fsm   = CCP_ST_IDLE;
                end
            end
            CCP_ST_IDLE: begin
                // exit inner zone is entered from the gap, so stays idle
                // reverse re-entry into the gap is not armed
                if (zone == CCP_ZONE_INNER && st.zone_prev == CCP_ZONE_OUTER) begin
                    next_st.fsm = CCP_ST_ARMED;
                end
            end
            CCP_ST_ARMED: begin
                if (zone == CCP_ZONE_GAP && st.zone_prev == CCP_ZONE_INNER) begin
                    // same code as last pulse gives no pulse
                    if (st.cur_valid && !(next_st.last_valid && st.cur_code == st.last_code)) begin
                        // fire at entry into the gap
                        next_st.fsm        = CCP_ST_PULSE;
                        next_st.pulse      = 1'b1;
                        next_st.cnt        = '0;
                        next_st.out_code   = st.cur_code;
                        next_st.out_stb    = 1'b1;
                        next_st.last_code  = st.cur_code;
                        next_st.last_valid = 1'b1;
                    end else begin
                        next_st.fsm = CCP_ST_IDLE;
                    end
                end else if (zone == CCP_ZONE_NONE || zone == CCP_ZONE_OUTER) begin
                    next_st.fsm = CCP_ST_IDLE;
                end
            end
            CCP_ST_PULSE: begin
                // width timed by a counter on mclk
                next_st.cnt = st.cnt + CNT_BITS'(1);
                if (st.cnt >= len_of(PULSE_LEN) - CNT_BITS'(1)) begin
                    next_st.pulse = 1'b0;
                    next_st.cnt   = '0;
                    next_st.fsm   = CCP_ST_IDLE;
                end
            end
            default: begin
                next_st.fsm = CCP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st           <= '0;
            st.fsm       <= CCP_ST_POWERUP;
            st.zone_prev <= CCP_ZONE_NONE;
            st.last_code <= CODE_RESET;
            // output held active from the reset itself onward
            st.pulse     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign code_out            = st.out_code;
    assign code_strobe         = st.out_stb;
    assign position_pulse      = st.pulse;
    assign carrier_indicator   = st.carrier;
    assign code_read_indicator = st.dataled;
endmodule : ccp_center_pulse

/* File: hdl/ccp_decode.sv */
// module: 24-bit raw marker sequence to 16-bit code decoder
`timescale 1ns/1ps
module ccp_decode
    import ccp_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // raw sequence in
    input  wire logic [RAW_BITS-1:0]  raw_seq,
    input  wire logic                 raw_valid,
    // decoded code out
    output logic      [CODE_BITS-1:0] dec_code,
    output logic                      dec_valid
);
    typedef struct packed {
        logic [CODE_BITS-1:0] code;
        logic                 valid;
    } ccp_dec_state_t;

    ccp_dec_state_t st;
    ccp_dec_state_t next_st;

    // layout: one framing bit in front of each group of two data bits;
    // a group is good when its framing bit is one
    function automatic logic frame_ok(input logic [RAW_BITS-1:0] s);
        logic ok;
        ok = 1'b1;
        for (int g = 0; g < GROUPS; g++) begin
            ok = ok & s[g*GROUP_BITS+FRAME_POS];
        end
        return ok;
    endfunction : frame_ok

    function automatic logic [CODE_BITS-1:0] strip(input logic [RAW_BITS-1:0] s);
        logic [CODE_BITS-1:0] c;
        c = '0;
        for (int g = 0; g < GROUPS; g++) begin
            c[g*GROUP_DATA]   = s[g*GROUP_BITS];
            c[g*GROUP_DATA+1] = s[g*GROUP_BITS+1];
        end
        return c;
    endfunction : strip

    always_comb begin
        next_st       = st;
        // only the 16 data bits leave
        next_st.valid = raw_valid && frame_ok(raw_seq);
        if (raw_valid && frame_ok(raw_seq)) begin
            next_st.code = strip(raw_seq);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dec_code  = st.code;
    assign dec_valid = st.valid;
endmodule : ccp_decode

/* File: shared/ccp_pkg.sv */
// package: constants and types for the centre crossing pulse logic
package ccp_pkg;
    localparam int CLK_MHZ             = 200;
    localparam int PULSE_MS            = 100;
    localparam int RESET_HOLD_MS       = 500;
    localparam int PULSE_CYCLES        = PULSE_MS * 1000 * CLK_MHZ;
    localparam int RESET_HOLD_CYCLES   = RESET_HOLD_MS * 1000 * CLK_MHZ;
    localparam int CODE_BITS           = 16;
    localparam int RAW_BITS            = 24;
    localparam int CNT_BITS            = 32;
    localparam int GROUP_BITS          = 3;
    localparam int GROUP_DATA          = 2;
    localparam int FRAME_POS           = 2;
    localparam int GROUPS              = RAW_BITS / GROUP_BITS;
    localparam logic [15:0] CODE_RESET = 16'h0000;

    // detection zone reported by the analogue front end
    typedef enum logic [1:0] {
        CCP_ZONE_NONE,
        CCP_ZONE_OUTER,
        CCP_ZONE_INNER,
        CCP_ZONE_GAP
    } ccp_zone_t;

    typedef enum logic [1:0] {
        CCP_ST_POWERUP,
        CCP_ST_IDLE,
        CCP_ST_ARMED,
        CCP_ST_PULSE
    } ccp_state_t;
endpackage : ccp_pkg

/* File: testbench/ccp_center_pulse_chk.sv */
// checker: port assertions for the centre crossing pulse logic
`timescale 1ns/1ps
module ccp_center_pulse_chk
    import ccp_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES,
    parameter int HOLD_LEN  = RESET_HOLD_CYCLES
)(
    // clock and reset
    input wire logic       mclk,
    input wire logic       resetn,
    // inputs
    input wire logic [1:0] zone_in,
    input wire logic       antenna_off,
    input wire logic       pulse_clear,
    // outputs
    input wire logic       code_strobe,
    input wire logic       position_pulse,
    input wire logic       carrier_indicator,
    input wire logic       code_read_indicator
);
    logic [CNT_BITS-1:0] hi_cnt;
    logic                hold_done;
    // hold_done keeps the power-up hold apart from real pulses
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hi_cnt    <= '0;
            hold_done <= 1'b0;
        end else begin
            hi_cnt    <= position_pulse ? hi_cnt + 1'b1 : '0;
            hold_done <= hold_done | !position_pulse;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_pulse_width: assert property ($fell(position_pulse) && hold_done |-> hi_cnt == PULSE_LEN)
        else $error("pulse width wrong");
    a_hold_len: assert property ($fell(position_pulse) && !hold_done |-> hi_cnt >= HOLD_LEN - 1)
        else $error("power-up hold too short");
    a_reset_hold: assert property ($rose(resetn) |-> position_pulse)
        else $error("pulse low right after reset");
    a_fire_code: assert property ($rose(position_pulse) && hold_done |-> code_strobe)
        else $error("pulse without code");
    a_gap_quiet: assert property ((zone_in == 2'h3)[*6] |-> !code_strobe && !code_read_indicator)
        else $error("activity inside gap");
    a_inner_lamps: assert property ((zone_in == 2'h2 && !antenna_off)[*4] |-> carrier_indicator && code_read_indicator)
        else $error("inner lamps wrong");
    a_outer_lamp: assert property ((zone_in == 2'h1 && !antenna_off)[*4] |-> code_read_indicator && !carrier_indicator)
        else $error("outer lamps wrong");
    a_off_dark: assert property (antenna_off[*4] |-> !code_read_indicator && !code_strobe)
        else $error("detection while off");
    cover property ($rose(position_pulse) && hold_done);
    cover property (antenna_off && zone_in == 2'h2);
    cover property (pulse_clear);
endmodule : ccp_center_pulse_chk

bind ccp_center_pulse ccp_center_pulse_chk #(.PULSE_LEN(PULSE_LEN), .HOLD_LEN(HOLD_LEN)) chk_u (
    .mclk(mclk), .resetn(resetn), .zone_in(zone_in), .antenna_off(antenna_off), .pulse_clear(pulse_clear),
    .code_strobe(code_strobe), .position_pulse(position_pulse), .carrier_indicator(carrier_indicator),
    .code_read_indicator(code_read_indicator));

/* File: testbench/ccp_ctrl_model.sv */
// vehicle controller model: sends commands, watches pulse and codes
`timescale 1ns/1ps
module ccp_ctrl_model
    import ccp_pkg::*;
(
    // clock and bench requests
    input wire logic                 mclk,
    input wire logic                 req_clear,
    input wire logic                 req_off,
    // device outputs
    input wire logic                 position_pulse,
    input wire logic                 code_strobe,
    input wire logic [CODE_BITS-1:0] code_out,
    // commands and observations
    output logic                     pulse_clear = 1'b0,
    output logic                     antenna_off = 1'b0,
    output int                       pulse_hi    = 0,
    output int                       strobe_n    = 0,
    output logic [CODE_BITS-1:0]     last_code   = '0,
    output logic [CODE_BITS-1:0]     pulse_code  = '0
);
    // commands move by non-blocking update on the rising edge
    // so the bench's falling-edge requests never race the model's sampling
    always @(posedge mclk) begin
        pulse_clear <= req_clear;
        antenna_off <= req_off;
    end
    // pulse counted per cycle so a spurious one after reversal shows
    always @(posedge mclk) begin
        pulse_hi <= pulse_hi + int'(position_pulse);
        strobe_n <= strobe_n + int'(code_strobe);
        if (code_strobe) last_code <= code_out;
        // the code that leaves together with the pulse
        if (code_strobe && position_pulse) pulse_code <= code_out;
    end
endmodule : ccp_ctrl_model

/* File: testbench/testbench.sv */
// testbench: crossing scenarios for the centre crossing pulse logic
`timescale 1ns/1ps
module testbench;
    import ccp_pkg::*;
    localparam int PL = 20;
    localparam int HL = 30;
    logic mclk = 1'b0, resetn = 1'b0, raw_valid = 1'b0, req_clear = 1'b0, req_off = 1'b0;
    logic [1:0] zone_in = 2'h0;
    logic [RAW_BITS-1:0] raw_seq = '0;
    logic pulse_clear, antenna_off, code_strobe, position_pulse, carrier_indicator, code_read_indicator;
    logic [CODE_BITS-1:0] code_out, last_code, pulse_code;
    int pulse_hi, strobe_n, err_total = 0, total_checks = 0;
    always #2.5 mclk = ~mclk;
    ccp_center_pulse #(.PULSE_LEN(PL), .HOLD_LEN(HL)) dut_u (.mclk(mclk), .resetn(resetn), .zone_in(zone_in),
        .raw_seq(raw_seq), .raw_valid(raw_valid), .pulse_clear(pulse_clear), .antenna_off(antenna_off),
        .code_out(code_out), .code_strobe(code_strobe), .position_pulse(position_pulse),
        .carrier_indicator(carrier_indicator), .code_read_indicator(code_read_indicator));
    ccp_ctrl_model ctrl_u (.mclk(mclk), .req_clear(req_clear), .req_off(req_off), .position_pulse(position_pulse),
        .code_strobe(code_strobe), .code_out(code_out), .pulse_clear(pulse_clear), .antenna_off(antenna_off),
        .pulse_hi(pulse_hi), .strobe_n(strobe_n), .last_code(last_code), .pulse_code(pulse_code));
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [15:0] c);
        for (int g = 0; g < 8; g++) raw_seq[3*g +: 3] = {1'b1, c[2*g+1], c[2*g]};
        raw_valid = 1'b1;
        step(3);
        raw_valid = 1'b0;
        step(3);
    endtask : send
    // one marker passage: entry zone, gap, exit zone, optional reversal into the gap
    task automatic pass(input logic [15:0] c, input bit inn, input bit rev, input bit off, input bit fire);
        int p, s;
        p = pulse_hi;
        s = strobe_n;
        req_off = off;
        zone_in = 2'h1;
        step(6);
        send(c);
        chk(code_read_indicator, !off);
        if (!off) chk(last_code, c);
        if (inn) begin
            zone_in = 2'h2;
            step(6);
            chk(carrier_indicator, !off);
        end
        zone_in = 2'h3;
        step(6);
        send(c);
        chk(code_read_indicator, 0);
        step(20);
        zone_in = inn ? 2'h2 : 2'h1;
        step(6);
        send(c);
        if (rev) begin
            zone_in = 2'h3;
            step(8);
            zone_in = 2'h2;
            step(6);
        end
        zone_in = 2'h0;
        req_off = 1'b0;
        step(30);
        chk(pulse_hi - p, fire ? PL : 0);
        if (fire) chk(pulse_code, c);
        chk(strobe_n - s, off ? 0 : 2 + fire);
    endtask : pass
    task automatic sc_reset;
        int n;
        n = 0;
        step(5);
        chk(position_pulse, 1);
        resetn = 1'b1;
        while (position_pulse === 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        chk(n >= HL - 1 && n <= HL + 1, 1);
    endtask : sc_reset
    task automatic sc_repeat_clear;
        pass(16'hA5C3, 1, 0, 0, 1);
        pass(16'hA5C3, 1, 0, 0, 0);
        req_clear = 1'b1;
        step(1);
        req_clear = 1'b0;
        pass(16'hA5C3, 1, 0, 0, 1);
    endtask : sc_repeat_clear
    task automatic sc_outer_reverse;
        pass(16'h1234, 0, 0, 0, 0);
        pass(16'hA5C3, 1, 1, 0, 1);
    endtask : sc_outer_reverse
    task automatic sc_off;
        pass(16'hFFFF, 1, 0, 1, 0);
        pass(16'h0001, 1, 0, 0, 1);
    endtask : sc_off
    task automatic final_report;
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        sc_reset;
        sc_repeat_clear;
        sc_outer_reverse;
        sc_off;
        final_report;
    end
    // about 700 cycles are needed; a hang is cut well beyond that
    initial begin
        step(20000);
        err_total++;
        final_report;
    end
endmodule : testbench
